// >>> src/ifm_fault_monitor.sv
// internal fault monitor: supply windows, oscillator, mux, checksum and image checks
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/100ps

module ifm_fault_monitor
   import ifm_pkg::*;
#(
   parameter logic [15:0] OSC_EXP = ifm_pkg::OSC_EXPECT,
   parameter logic [15:0] OSC_TL  = ifm_pkg::OSC_TOL
) (
   // clock, reset, enable
   input  wire logic                      sys_clk,
   input  wire logic                      resetn,
   input  wire logic                      clk_en,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [ifm_pkg::ADDR_W-1:0] paddr,
   input  wire logic [ifm_pkg::DATA_W-1:0] pwdata,
   output logic      [ifm_pkg::DATA_W-1:0] prdata,
   output logic                           pready,
   output logic                           pslverr,
   // power-good windows: v3p3, v2p5, vcc, vref
   input  wire logic [3:0]                pg_ok,
   // oscillator and independent timer ticks
   input  wire logic                      osc_a_tick,
   input  wire logic                      osc_b_tick,
   input  wire logic                      timer_tick,
   // scan engine status
   input  wire logic                      scan_start,
   input  wire logic                      scan_continuous,
   input  wire logic                      temp_scan_active,
   input  wire logic                      temp_input_mux_test_bit_res_valid,
   input  wire logic [13:0]               temp_input_mux_test_bit_res_code,
   input  wire logic                      ref2_valid,
   input  wire logic [13:0]               ref2_code,
   input  wire logic [15:0]               nvm_factory_sig,
   // host link side
   input  wire logic                      host_read_cmd,
   output logic                           fault_resp_send,
   output logic                           fault_resp_prepend,
   // fault pin, interrupt, mux test drive
   output logic                           fault_n,
   output logic                           irq,
   output logic                           temp_input_mux_test_bit
);
   import ifm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   // one step of the signature compression
   function automatic logic [15:0] ifm_misr_step(input logic [15:0] s, input logic [15:0] w);
      ifm_misr_step = {s[14:0], 1'b0} ^ (s[15] ? MISR_POLY : 16'h0000) ^ w;
   endfunction

   // word-store window decode
   function automatic logic ifm_is_mem(input logic [11:0] a);
      ifm_is_mem = (a[11:8] == OFS_MEM_BASE[11:8]) && (a[7] == 1'b0);
   endfunction

   // counts outside expected window
   function automatic logic ifm_off(input logic [15:0] v, input logic [15:0] e,
                                    input logic [15:0] t);
      ifm_off = (v > e + t) || (v + t < e);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [FLAG_W-1:0] status_q, status_d, flag_set, mask_q;
   logic              pending_q;
   logic [15:0]       stored_sig_q, nvm_calc_q, ref2_q, temp_input_mux_test_bit_lo_q, temp_input_mux_test_bit_hi_q;
   logic [15:0]       osc_a_q, osc_b_q;
   logic              ack_q, go, mem_hit, reg_hit, wr_fire;
   logic              mem_sel_q;
   logic [31:0]       prd_q, rd_mux;
   logic [2:0]        req_q;
   ifm_eng_state_e    eng_q;
   ifm_eng_mode_e     mode_q;
   logic [4:0]        cnt_q;
   logic              rd_vld_q, eng_issue, eng_start;
   logic [15:0]       acc_q;
   logic              mem_en, mem_we;
   logic [4:0]        mem_addr;
   logic [15:0]       mem_rdata;
   logic              osc_bad, temp_input_mux_test_bit_bad, ck_bad, nvm_bad, new_fault;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: every access takes at least two access cycles
   assign mem_hit = ifm_is_mem(paddr);
   // store access waits while the signature engine owns the port
   assign go      = psel && penable && (!mem_hit || eng_q == ENG_IDLE);
   assign pready  = psel && penable && ack_q;
   assign wr_fire = go && ack_q && pwrite;

   always_comb begin
      reg_hit = 1'b1;
      rd_mux  = 32'h0000_0000;
      case (paddr)
         OFS_STATUS:   rd_mux[FLAG_W-1:0] = status_q;
         OFS_MASK:     rd_mux[FLAG_W-1:0] = mask_q;
         OFS_CTRL:     rd_mux[CTRL_TEMP_INPUT_MUX_TEST_BIT_TEST] = temp_input_mux_test_bit;
         OFS_CMD:      rd_mux = 32'h0000_0000;
         OFS_SETUP_SG: rd_mux[15:0] = stored_sig_q;
         OFS_NVM_CALC: rd_mux[15:0] = nvm_calc_q;
         OFS_NVM_FACT: rd_mux[15:0] = nvm_factory_sig;
         OFS_REF2:     rd_mux[15:0] = ref2_q;
         OFS_TEMP_INPUT_MUX_TEST_BIT_LIM: rd_mux = {temp_input_mux_test_bit_hi_q, temp_input_mux_test_bit_lo_q};
         OFS_ENGINE:   rd_mux = {26'h000_0000, pending_q, req_q, eng_q};
         default:      reg_hit = mem_hit;
      endcase
   end

   assign pslverr = pready && !reg_hit;
   assign prdata  = mem_sel_q ? {16'h0000, mem_rdata} : prd_q;

   // handshake and read capture
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ack_q     <= 1'b0;
         prd_q     <= 32'h0000_0000;
         mem_sel_q <= 1'b0;
      end else if (clk_en) begin
         ack_q <= go && !ack_q;
         if (go && !ack_q) begin
            prd_q     <= rd_mux;
            mem_sel_q <= mem_hit;
         end
      end
   end

   // software controls
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         mask_q                  <= MASK_RST;
         temp_input_mux_test_bit <= 1'b0;
         temp_input_mux_test_bit_lo_q               <= TEMP_INPUT_MUX_TEST_BIT_LO_RST;
         temp_input_mux_test_bit_hi_q               <= TEMP_INPUT_MUX_TEST_BIT_HI_RST;
      end else if (clk_en && wr_fire) begin
         if (paddr == OFS_MASK) begin
            mask_q <= pwdata[FLAG_W-1:0];
         end
         if (paddr == OFS_CTRL) begin
            temp_input_mux_test_bit <= pwdata[CTRL_TEMP_INPUT_MUX_TEST_BIT_TEST];
         end
         if (paddr == OFS_TEMP_INPUT_MUX_TEST_BIT_LIM) begin
            temp_input_mux_test_bit_lo_q <= pwdata[15:0];
            temp_input_mux_test_bit_hi_q <= pwdata[31:16];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fault detectors
   // oscillators counted over one independent timer period
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         osc_a_q <= 16'h0000;
         osc_b_q <= 16'h0000;
      end else if (clk_en) begin
         if (timer_tick) begin
            osc_a_q <= {15'h0000, osc_a_tick};
            osc_b_q <= {15'h0000, osc_b_tick};
         end else begin
            // saturate so a runaway oscillator cannot wrap back into range
            if (osc_a_tick && osc_a_q != 16'hffff) osc_a_q <= osc_a_q + 16'h0001;
            if (osc_b_tick && osc_b_q != 16'hffff) osc_b_q <= osc_b_q + 16'h0001;
         end
      end
   end

   // a against timer, b against timer, and a against b
   assign osc_bad = timer_tick && (ifm_off(osc_a_q, OSC_EXP, OSC_TL)
                    || ifm_off(osc_b_q, OSC_EXP, OSC_TL)
                    || ifm_off(osc_a_q, osc_b_q, OSC_TL));

   // known-voltage results during a temperature scan
   assign temp_input_mux_test_bit_bad = temp_input_mux_test_bit_res_valid && temp_scan_active
                     && ({2'b00, temp_input_mux_test_bit_res_code} < temp_input_mux_test_bit_lo_q
                     || {2'b00, temp_input_mux_test_bit_res_code} > temp_input_mux_test_bit_hi_q);

   // second reference result kept for the host
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ref2_q <= 16'h0000;
      end else if (clk_en && ref2_valid) begin
         ref2_q <= {2'b00, ref2_code};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // signature engine over the word store
   // queued requests: bit0 calc, bit1 check, bit2 image
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         req_q <= 3'b000;
      end else if (clk_en) begin
         req_q <= (req_q & ~(eng_start ? (req_q[1] ? 3'b010 : req_q[0] ? 3'b001 : 3'b100)
                                       : 3'b000))
                  | {scan_start,
                     wr_fire && paddr == OFS_CMD && pwdata[CMD_CHECK],
                     wr_fire && paddr == OFS_CMD && pwdata[CMD_CALC]};
      end
   end

   // never start under a store access already in progress
   assign eng_start = (eng_q == ENG_IDLE) && (req_q != 3'b000) && !(psel && mem_hit);
   assign eng_issue = (eng_q == ENG_WALK) && (cnt_q < 5'(WALK_WORDS));

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         eng_q    <= ENG_IDLE;
         mode_q   <= MODE_CALC;
         cnt_q    <= 5'h00;
         rd_vld_q <= 1'b0;
         acc_q    <= MISR_SEED;
      end else if (clk_en) begin
         rd_vld_q <= eng_issue;
         case (eng_q)
            ENG_IDLE: begin
               if (eng_start) begin
                  eng_q  <= ENG_WALK;
                  cnt_q  <= 5'h00;
                  acc_q  <= MISR_SEED;
                  mode_q <= req_q[1] ? MODE_CHECK : req_q[0] ? MODE_CALC : MODE_NVM;
               end
            end
            ENG_WALK: begin
               if (eng_issue) cnt_q <= cnt_q + 5'h01;
               if (rd_vld_q) acc_q <= ifm_misr_step(acc_q, mem_rdata);
               if (!eng_issue && !rd_vld_q) eng_q <= ENG_DONE;
            end
            ENG_DONE: eng_q <= ENG_IDLE;
            default:  eng_q <= ENG_IDLE;
         endcase
      end
   end

   // results of a finished walk
   assign ck_bad  = (eng_q == ENG_DONE) && (mode_q == MODE_CHECK)
                    && (acc_q != stored_sig_q);
   assign nvm_bad = (eng_q == ENG_DONE) && (mode_q == MODE_NVM)
                    && (acc_q != nvm_factory_sig);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         stored_sig_q <= MISR_SEED;
         nvm_calc_q   <= 16'h0000;
      end else if (clk_en && eng_q == ENG_DONE) begin
         if (mode_q == MODE_CALC) stored_sig_q <= acc_q;
         if (mode_q == MODE_NVM)  nvm_calc_q   <= acc_q;
      end
   end

   // store port: engine first, else the apb transfer
   always_comb begin
      mem_en   = eng_issue || (go && mem_hit);
      mem_we   = !eng_issue && wr_fire && mem_hit;
      mem_addr = eng_issue ? ((mode_q == MODE_NVM) ? NVM_BASE : SETUP_BASE) + cnt_q
                           : paddr[6:2];
   end

   ifm_word_mem #(
      .WIDTH (16),
      .DEPTH (MEM_WORDS),
      .AW    (MEM_AW)
   ) u_mem (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .clk_en  (clk_en),
      .en      (mem_en),
      .we      (mem_we),
      .addr    (mem_addr),
      .wdata   (pwdata[15:0]),
      .rdata   (mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // status, fault pin, interrupt, fault response
   always_comb begin
      flag_set            = '0;
      flag_set[FLG_REF]   = !pg_ok[3];
      flag_set[FLG_REG]   = !(&pg_ok[2:0]);
      flag_set[FLG_OSC]   = osc_bad;
      flag_set[FLG_TMX]   = temp_input_mux_test_bit_bad;
      flag_set[FLG_CKSUM] = ck_bad;
      flag_set[FLG_NVM]   = nvm_bad;
      // write-one-clear, but a fresh set in the same cycle wins
      status_d = status_q;
      if (wr_fire && paddr == OFS_STATUS) status_d = status_q & ~pwdata[FLAG_W-1:0];
      status_d = status_d | flag_set;
   end

   assign new_fault = |(flag_set & ~status_q);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         status_q <= '0;
         fault_n  <= 1'b1;
         irq      <= 1'b0;
      end else if (clk_en) begin
         status_q <= status_d;
         fault_n  <= ~|status_d;
         irq      <= |(status_d & mask_q);
      end
   end

   // response goes out now when scanning, else waits for the next read
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pending_q          <= 1'b0;
         fault_resp_send    <= 1'b0;
         fault_resp_prepend <= 1'b0;
      end else if (clk_en) begin
         fault_resp_send    <= new_fault && scan_continuous;
         fault_resp_prepend <= host_read_cmd && pending_q;
         pending_q <= (pending_q && !host_read_cmd)
                      || (new_fault && !scan_continuous);
      end
   end

endmodule

// >>> src/ifm_pkg.sv
// shared constants and types for the internal fault monitor
package ifm_pkg;

   // apb geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   // register byte offsets
   localparam logic [11:0] OFS_STATUS   = 12'h000;
   localparam logic [11:0] OFS_MASK     = 12'h004;
   localparam logic [11:0] OFS_CTRL     = 12'h008;
   localparam logic [11:0] OFS_CMD      = 12'h00c;
   localparam logic [11:0] OFS_SETUP_SG = 12'h010;
   localparam logic [11:0] OFS_NVM_CALC = 12'h014;
   localparam logic [11:0] OFS_NVM_FACT = 12'h018;
   localparam logic [11:0] OFS_REF2     = 12'h01c;
   localparam logic [11:0] OFS_TEMP_INPUT_MUX_TEST_BIT_LIM = 12'h020;
   localparam logic [11:0] OFS_ENGINE   = 12'h024;
   localparam logic [11:0] OFS_MEM_BASE = 12'h100;

   // word store: setup image low half, nvm shadow image high half
   localparam int unsigned MEM_AW     = 5;
   localparam int unsigned MEM_WORDS  = 32;
   localparam int unsigned WALK_WORDS = 16;
   localparam logic [4:0]  SETUP_BASE = 5'h00;
   localparam logic [4:0]  NVM_BASE   = 5'h10;

   // status / mask bit positions
   localparam int unsigned FLAG_W     = 6;
   localparam int unsigned FLG_REF    = 0;
   localparam int unsigned FLG_REG    = 1;
   localparam int unsigned FLG_OSC    = 2;
   localparam int unsigned FLG_TMX    = 3;
   localparam int unsigned FLG_CKSUM  = 4;
   localparam int unsigned FLG_NVM    = 5;

   // control and command bit positions
   localparam int unsigned CTRL_TEMP_INPUT_MUX_TEST_BIT_TEST = 0;
   localparam int unsigned CMD_CALC       = 0;
   localparam int unsigned CMD_CHECK      = 1;

   // reset values and signature polynomial
   localparam logic [5:0]  MASK_RST     = 6'h3f;
   localparam logic [15:0] TEMP_INPUT_MUX_TEST_BIT_LO_RST  = 16'h0100;
   localparam logic [15:0] TEMP_INPUT_MUX_TEST_BIT_HI_RST  = 16'h3f00;
   localparam logic [15:0] MISR_SEED    = 16'hffff;
   localparam logic [15:0] MISR_POLY    = 16'h1021;

   // oscillator cross-check counts per independent timer period
   localparam logic [15:0] OSC_EXPECT   = 16'h0064;
   localparam logic [15:0] OSC_TOL      = 16'h0004;

   typedef enum logic [1:0] {ENG_IDLE, ENG_WALK, ENG_DONE} ifm_eng_state_e;
   typedef enum logic [1:0] {MODE_CALC, MODE_CHECK, MODE_NVM} ifm_eng_mode_e;

endpackage

// >>> src/ifm_word_mem.sv
// single-port word store with registered read data
`timescale 1ns/100ps

module ifm_word_mem #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 32,
   parameter int unsigned AW    = 5
) (
   // clock, reset, enable
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic             clk_en,
   // access port
   input  wire logic             en,
   input  wire logic             we,
   input  wire logic [AW-1:0]    addr,
   input  wire logic [WIDTH-1:0] wdata,
   output logic      [WIDTH-1:0] rdata
);

   // array holds no reset; contents are loaded by software
   logic [WIDTH-1:0] mem_q [DEPTH];

   // write port
   always_ff @(posedge sys_clk) begin
      if (clk_en && en && we) begin
         mem_q[addr] <= wdata;
      end
   end

   // read data register, one cycle after the request
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rdata <= '0;
      end else if (clk_en && en) begin
         rdata <= mem_q[addr];
      end
   end

endmodule

// >>> test/ifm_osc_model.sv
// oscillator pair and independent timer tick source
`timescale 1ns/100ps

module ifm_osc_model #(
   parameter int unsigned TMR_PER = 1000,
   parameter int unsigned A_PER   = 10
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   // second oscillator period, A_PER when healthy
   input  wire logic [3:0] b_period,
   // ticks
   output logic            osc_a_tick,
   output logic            osc_b_tick,
   output logic            timer_tick
);
   int unsigned a_q, b_q, t_q;

   // dividers restart together so a healthy pair counts evenly per timer period
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         a_q <= 0;
         b_q <= 0;
         t_q <= 0;
      end else begin
         a_q <= (a_q >= A_PER - 1) ? 0 : a_q + 1;
         b_q <= (b_q >= b_period - 1) ? 0 : b_q + 1; // >= so a shorter period never runs away
         t_q <= (t_q >= TMR_PER - 1) ? 0 : t_q + 1;
      end
   end

   assign osc_a_tick = resetn && a_q == A_PER - 1;
   assign osc_b_tick = resetn && b_q == b_period - 1;
   assign timer_tick = resetn && t_q == TMR_PER - 1;
endmodule

// >>> test/ifm_fault_monitor_monitor.sv
// port assertions for the internal fault monitor
`timescale 1ns/100ps

module ifm_fault_monitor_chk
   import ifm_pkg::*;
(
   // clock, reset, enable
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        clk_en,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // fault side
   input wire logic [3:0]  pg_ok,
   input wire logic        scan_continuous,
   input wire logic        host_read_cmd,
   input wire logic        fault_resp_send,
   input wire logic        fault_resp_prepend,
   input wire logic        fault_n,
   input wire logic        irq,
   input wire logic        temp_input_mux_test_bit
);
   // a frozen clock enable holds everything, so it suspends checking too
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn || !clk_en);

   sequence s_wr_done(logic [11:0] a);
      psel && penable && pready && pwrite && paddr == a;
   endsequence
   sequence s_prepend;
      fault_resp_prepend ##1 !fault_resp_prepend;
   endsequence

   a_ref_window: assert property (!pg_ok[3] |-> ##[1:2] !fault_n)
      else $error("reference out of window, fault pin high");
   a_reg_window: assert property (!(&pg_ok[2:0]) |-> ##[1:2] !fault_n)
      else $error("regulator out of window, fault pin high");
   a_send_cont: assert property (fault_resp_send |->
      $past(scan_continuous) || $past(scan_continuous, 2))
      else $error("fault response sent outside continuous scan");
   a_irq_pin: assert property ($rose(irq) |-> !fault_n)
      else $error("interrupt without fault pin low");
   a_prepend_read: assert property (fault_resp_prepend |-> $past(host_read_cmd))
      else $error("prepend without host read");
   a_prepend_pulse: assert property (fault_resp_prepend |-> s_prepend)
      else $error("prepend longer than one cycle");
   a_flag_sticky: assert property (!fault_n &&
      !(psel && pwrite && paddr == OFS_STATUS) |=> !fault_n)
      else $error("fault pin released without status clear");
   a_mux_bit: assert property (s_wr_done(OFS_CTRL) |=>
      temp_input_mux_test_bit == $past(pwdata[0]))
      else $error("mux test bit not following control write");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
endmodule

bind ifm_fault_monitor ifm_fault_monitor_chk u_chk (
   .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .pg_ok(pg_ok), .scan_continuous(scan_continuous), .host_read_cmd(host_read_cmd),
   .fault_resp_send(fault_resp_send), .fault_resp_prepend(fault_resp_prepend),
   .fault_n(fault_n), .irq(irq), .temp_input_mux_test_bit(temp_input_mux_test_bit)
);

// >>> test/ifm_fault_monitor_tb_top.sv
// self-checking bench for the internal fault monitor
`timescale 1ns/100ps

module ifm_fault_monitor_tb_top;
   import ifm_pkg::*;
   // second reference code for 2.5v, scale is arbitrary
   localparam logic [13:0] REF2_NOM = 14'h2000;
   // temperature codes inside, at and beyond the default limits, last one outside a scan
   localparam logic [13:0] TCODE [6] = '{14'h0200, 14'h3f00, 14'h0100,
                                         14'h3f01, 14'h00ff, 14'h3fff};
   localparam logic [3:0]  TFLAG [6] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h8, 4'h0};
   logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        pready, pslverr, err, osc_a, osc_b, tmr, snd, prep, fault_n, irq, tbit;
   logic [3:0]  pg_ok = 4'hf, b_per = 4'ha;
   logic        scan_start = 1'b0, scan_cont = 1'b0, tscan = 1'b0, tval = 1'b0;
   logic        ref2_valid = 1'b0, host_rd = 1'b0;
   logic [13:0] tcode = 14'h0000, ref2_code = 14'h0000;
   logic [15:0] fact_sig = 16'h0000;
   logic [15:0] words [32];
   int          fail_count = 0, num_checks = 0, n_snd = 0, n_prep = 0;

   always #10 sys_clk = ~sys_clk;
   // pulses stand one cycle, so the falling edge sees each once
   always @(negedge sys_clk) begin
      n_snd += (snd === 1'b1);
      n_prep += (prep === 1'b1);
   end

   ifm_osc_model u_osc (.sys_clk(sys_clk), .resetn(resetn), .b_period(b_per),
      .osc_a_tick(osc_a), .osc_b_tick(osc_b), .timer_tick(tmr));
   ifm_fault_monitor uut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pg_ok(pg_ok), .osc_a_tick(osc_a),
      .osc_b_tick(osc_b), .timer_tick(tmr), .scan_start(scan_start),
      .scan_continuous(scan_cont), .temp_scan_active(tscan), .temp_input_mux_test_bit_res_valid(tval),
      .temp_input_mux_test_bit_res_code(tcode), .ref2_valid(ref2_valid), .ref2_code(ref2_code),
      .nvm_factory_sig(fact_sig), .host_read_cmd(host_rd), .fault_resp_send(snd),
      .fault_resp_prepend(prep), .fault_n(fault_n), .irq(irq), .temp_input_mux_test_bit(tbit));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one apb transfer; ready, read data and error are all taken at the completing edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      rd = prdata;
      err = pslverr;
      fail_count += (n >= 100);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string name);
      apb(1'b0, a, 32'h0000_0000);
      check(name, rd, exp);
   endtask

   // poll the engine register until no request is queued and the walk is idle
   task automatic cmd(input logic [31:0] d);
      int n;
      n = 0;
      if (d != 0)
         apb(1'b1, OFS_CMD, d);
      do begin
         apb(1'b0, OFS_ENGINE, 32'h0000_0000);
         n++;
      end while (rd[4:0] !== 5'h00 && n < 40);
      fail_count += (n >= 40);
   endtask

   task automatic pins(input logic fn, input logic iq);
      repeat (2) @(posedge sys_clk);
      check("fault_n", {31'h0, fault_n}, {31'h0, fn});
      check("irq", {31'h0, irq}, {31'h0, iq});
   endtask

   function automatic logic [15:0] misr(input int base);
      logic [15:0] s;
      s = MISR_SEED;
      for (int i = 0; i < 16; i++)
         s = {s[14:0], 1'b0} ^ (s[15] ? MISR_POLY : 16'h0000) ^ words[base + i];
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      rd_chk(OFS_STATUS, 32'h0000_0000, "status");
      rd_chk(OFS_MASK, 32'h0000_003f, "mask");
      rd_chk(OFS_SETUP_SG, 32'h0000_ffff, "setup sig");
      rd_chk(OFS_TEMP_INPUT_MUX_TEST_BIT_LIM, 32'h3f00_0100, "limits");
      rd_chk(OFS_CMD, 32'h0000_0000, "cmd");
      apb(1'b0, 12'h028, 32'h0000_0000);
      check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
      // setup checksum: calculate, check clean, corrupt a word, check again
      for (int i = 0; i < 32; i++) begin
         words[i] = 16'h1234 + 16'(i * 16'h0111);
         apb(1'b1, OFS_MEM_BASE + 12'(4 * i), {16'h0000, words[i]});
      end
      cmd(32'h0000_0001);
      rd_chk(OFS_SETUP_SG, {16'h0000, misr(0)}, "setup sig");
      cmd(32'h0000_0002);
      rd_chk(OFS_STATUS, 32'h0000_0000, "clean check");
      words[3] = ~words[3];
      apb(1'b1, OFS_MEM_BASE + 12'h00c, {16'h0000, words[3]});
      cmd(32'h0000_0002);
      rd_chk(OFS_STATUS, 32'h0000_0010, "dirty check");
      rd_chk(OFS_STATUS, 32'h0000_0010, "read keeps flag");
      check("no send", n_snd, 0);
      // pending response goes ahead of the next read only
      for (int k = 0; k < 2; k++) begin
         host_rd <= 1'b1;
         @(posedge sys_clk);
         host_rd <= 1'b0;
         repeat (2) @(posedge sys_clk);
         check("prepend", n_prep, 1);
      end
      apb(1'b1, OFS_STATUS, 32'h0000_0010);
      cmd(32'h0000_0001);
      cmd(32'h0000_0002);
      rd_chk(OFS_STATUS, 32'h0000_0000, "recalc clean");
      // image signature on a scan, matching and then mismatching
      for (int k = 0; k < 2; k++) begin
         fact_sig <= k ? ~misr(16) : misr(16);
         scan_start <= 1'b1;
         @(posedge sys_clk);
         scan_start <= 1'b0;
         cmd(32'h0000_0000);
         rd_chk(OFS_NVM_CALC, {16'h0000, misr(16)}, "nvm calc");
         rd_chk(OFS_NVM_FACT, {16'h0000, fact_sig}, "nvm fact");
         rd_chk(OFS_STATUS, k ? 32'h0000_0020 : 32'h0000_0000, "nvm flag");
      end
      pins(1'b0, 1'b1);
      apb(1'b1, OFS_MASK, 32'h0000_001f);
      pins(1'b0, 1'b0);
      apb(1'b1, OFS_MASK, 32'h0000_003f);
      apb(1'b1, OFS_STATUS, 32'h0000_0020);
      pins(1'b1, 1'b0);
      ref2_code <= REF2_NOM;
      ref2_valid <= 1'b1;
      @(posedge sys_clk);
      ref2_valid <= 1'b0;
      rd_chk(OFS_REF2, {18'h0, REF2_NOM}, "ref2");
      // mux self-test results against the limits
      apb(1'b1, OFS_CTRL, 32'h0000_0001);
      pins(1'b1, 1'b0);
      check("mux bit", {31'h0, tbit}, 32'h0000_0001);
      for (int k = 0; k < 6; k++) begin
         tscan <= (k < 5);
         tcode <= TCODE[k];
         tval <= 1'b1;
         @(posedge sys_clk);
         tval <= 1'b0;
         rd_chk(OFS_STATUS, {28'h0, TFLAG[k]}, "mux flag");
         apb(1'b1, OFS_STATUS, 32'h0000_0008);
      end
      // window faults while scanning continuously; a repeated flag sends nothing new
      scan_cont <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         pg_ok <= ~(4'h8 >> k);
         repeat (3) @(posedge sys_clk);
         pg_ok <= 4'hf;
         rd_chk(OFS_STATUS, k ? 32'h0000_0003 : 32'h0000_0001, "window flag");
         check("send", n_snd, k ? 2 : 1);
      end
      apb(1'b1, OFS_STATUS, 32'h0000_0003);
      // slow second oscillator, then healthy again
      b_per <= 4'hc;
      repeat (2100) @(posedge sys_clk);
      b_per <= 4'ha;
      repeat (2100) @(posedge sys_clk);
      rd_chk(OFS_STATUS, 32'h0000_0004, "osc flag");
      apb(1'b1, OFS_STATUS, 32'h0000_0004);
      repeat (2100) @(posedge sys_clk);
      rd_chk(OFS_STATUS, 32'h0000_0000, "osc clean");
      tally_and_finish();
   end

   // watchdog well beyond the roughly 7000 cycles the sequence needs
   initial begin
      repeat (40000) @(posedge sys_clk);
      fail_count++;
      tally_and_finish();
   end
endmodule
